// ==== common/lahp_defs.svh ====
// Constants of the line alarm and host port block: counts, offsets, reset values.
// Assumes it is included by bare name wherever a constant is needed.
`ifndef LAHP_DEFS_SVH
`define LAHP_DEFS_SVH

// ----------------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------------
`define LAHP_CHANNELS     6
`define LAHP_ADDR_W       8
`define LAHP_DATA_W       8
`define LAHP_CMD_REGS     32

// ----------------------------------------------------------------------------
// Alarm timing
// ----------------------------------------------------------------------------
`define LAHP_IDLE_TXCLK   128
`define LAHP_IDLE_TOL     32
`define LAHP_LOCK_WINDOW  1024
`define LAHP_LOCK_PPT     5
`define LAHP_LOCK_DEN     1000

// ----------------------------------------------------------------------------
// Host port map and reset values
// ----------------------------------------------------------------------------
`define LAHP_ADDR_EVENT   8'h40
`define LAHP_ADDR_INTEN   8'h43
`define LAHP_ADDR_LIVE    8'h44
`define LAHP_KINDS        3
`define LAHP_CMD_RESET    8'h00
`define LAHP_INTEN_RESET  3'h0

`endif

// ==== common/lahp_pkg.sv ====
// Types shared by the line alarm and host port block.
// Assumes nothing beyond a SystemVerilog compiler.
package lahp_pkg;

	// Alarm set of one channel, as the channel logic reports it.
	typedef struct packed {
		logic driverFault;
		logic signalAbsent;
		logic lockFailure;
	} lahp_alarm_t;

	// Host control pins after synchronisation.
	typedef struct packed {
		logic chipSelN;
		logic writeN;
		logic readN;
		logic regResetN;
		logic timingSel;
		logic hostClock;
		logic boardTestFloat;
	} lahp_host_pins_t;

endpackage

// ==== hw/lahp_channel_alarm.sv ====
// Alarm detection of one line channel: driver monitor, signal absence, lock check.
// Assumes every pin clock is well below half of clk_sys, so each edge is seen.
`include "lahp_defs.svh"
module lahp_channel_alarm #(
	parameter int IDLE_TXCLK  = `LAHP_IDLE_TXCLK,
	parameter int LOCK_WINDOW = `LAHP_LOCK_WINDOW
) (
	input  wire logic          clk_sys,
	input  wire logic          rst,
	input  wire logic          txLineClock,
	input  wire logic          monitorPosInput,
	input  wire logic          monitorNegInput,
	input  wire logic          recoveredClock,
	input  wire logic          referenceClock,
	input  wire logic          signalAbsentCondition,
	output lahp_pkg::lahp_alarm_t alarm
);

	localparam int             CW       = $clog2(2 * LOCK_WINDOW + 1);
	localparam int             TOL      = (LOCK_WINDOW * `LAHP_LOCK_PPT) / `LAHP_LOCK_DEN;
	localparam logic [7:0]     IDLE_END = 8'(IDLE_TXCLK - 1);
	localparam logic [CW-1:0]  REF_LAST = CW'(LOCK_WINDOW - 1);
	localparam logic [CW-1:0]  REC_HI   = CW'(LOCK_WINDOW + TOL);
	localparam logic [CW-1:0]  REC_LO   = CW'(LOCK_WINDOW - TOL);
	localparam logic [CW-1:0]  REC_MAX  = CW'(2 * LOCK_WINDOW);
	localparam logic [CW-1:0]  ONE      = CW'(1);

	logic [5:0]    pinS;
	logic [5:0]    pinPrev;
	logic [7:0]    idleCnt;
	logic [CW-1:0] refCnt;
	logic [CW-1:0] recCnt;
	logic          driverFault;
	logic          signalAbsent;
	logic          lockFailure;

	// ------------------------------------------------------------------------
	// Pin sampling
	// ------------------------------------------------------------------------
	// Monitor inputs idle high because they are pulled up on the board.
	lahp_sync2 #(
		.WIDTH (6),
		.INIT  (6'h18)
	) u_pins (
		.clk_sys (clk_sys),
		.rst     (rst),
		.din     ({txLineClock, monitorPosInput, monitorNegInput,
		           recoveredClock, referenceClock, signalAbsentCondition}),
		.dout    (pinS)
	);

	// Edge and transition decode on the synchronised pins.
	wire txEdge        = pinS[5] & ~pinPrev[5];
	wire monTransition = (pinS[4] ^ pinPrev[4]) | (pinS[3] ^ pinPrev[3]);
	wire recEdge       = pinS[2] & ~pinPrev[2];
	wire refEdge       = pinS[1] & ~pinPrev[1];
	wire faultSet      = txEdge & ~monTransition & (idleCnt == IDLE_END);
	wire windowEnd     = refEdge & (refCnt == REF_LAST);
	wire [CW-1:0] recNext = (recEdge && recCnt != REC_MAX) ? recCnt + ONE : recCnt;
	wire lockOut       = (recNext > REC_HI) | (recNext < REC_LO);

	// ------------------------------------------------------------------------
	// Driver monitor
	// ------------------------------------------------------------------------
	// The idle count runs on transmit clock edges and restarts on any monitor pulse.
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			pinPrev     <= 6'h18;
			idleCnt     <= 8'h00;
			driverFault <= 1'b0;
		end
		else
		begin
			pinPrev <= pinS;
			if (monTransition)
				idleCnt <= 8'h00;
			else if (txEdge && idleCnt != IDLE_END)
				idleCnt <= idleCnt + 8'h01;
			if (faultSet)
				driverFault <= 1'b1;
			else if (monTransition)
				driverFault <= 1'b0;
		end
	end

	// ------------------------------------------------------------------------
	// Signal absence and lock check
	// ------------------------------------------------------------------------
	// Recovered edges are counted over a fixed number of reference edges; the
	// check reacts only once per window, which trades speed for a clean ratio.
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			refCnt       <= '0;
			recCnt       <= '0;
			lockFailure  <= 1'b0;
			signalAbsent <= 1'b0;
		end
		else
		begin
			signalAbsent <= pinS[0];
			recCnt       <= windowEnd ? '0 : recNext;
			if (windowEnd)
			begin
				refCnt      <= '0;
				lockFailure <= lockOut;
			end
			else if (refEdge)
				refCnt <= refCnt + ONE;
		end
	end

	assign alarm = '{driverFault: driverFault, signalAbsent: signalAbsent,
	                 lockFailure: lockFailure};

	// ------------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	a_fault_raise: assert property (faultSet |=> driverFault)
		else $error("driver fault not raised after idle monitor");
	a_fault_clear: assert property (driverFault && monTransition && !faultSet |=> !driverFault)
		else $error("driver fault not cleared by monitor pulse");
	a_absent_follow: assert property (signalAbsentCondition [*4] |-> alarm.signalAbsent)
		else $error("signal absent flag does not follow condition");
	a_lock_judge: assert property (windowEnd |=> lockFailure == $past(lockOut))
		else $error("lock failure not judged at window end");

endmodule

// ==== hw/lahp_line_alarm_top.sv ====
// Per-channel line alarms and the parallel host port of a six channel line unit.
// Assumes every pin input is asynchronous to clk_sys and the host clock is slow enough
// for clk_sys to see its edges; board pads turn each output enable into a tristate.
//
// Overview of operation
// - Idle monitor for 128 transmit clocks raises fault.
// - Fault stays until monitor pulses return.
// - Signal absent flag follows receiver condition.
// - Lock flag when recovered clock deviates beyond 0.5%.
// - Low float input disables every output.
// - Write strobe stores data into addressed register.
// - Read strobe drives addressed register onto bus.
// - Register reset low restores all defaults.
// - Timing select high times writes on host clock edges.
// - Timing select low uses the internal clock.
// - Eight bit address and data buses.
// - Interrupt pin held low until serviced.
`include "lahp_defs.svh"
module lahp_line_alarm_top #(
	parameter int CHANNELS    = `LAHP_CHANNELS,
	parameter int CMD_REGS    = `LAHP_CMD_REGS,
	parameter int IDLE_TXCLK  = `LAHP_IDLE_TXCLK,
	parameter int LOCK_WINDOW = `LAHP_LOCK_WINDOW
) (
	input  wire logic                    clk_sys,
	input  wire logic                    rst,
	input  wire logic [CHANNELS-1:0]     txLineClock,
	input  wire logic [CHANNELS-1:0]     monitorPosInput,
	input  wire logic [CHANNELS-1:0]     monitorNegInput,
	input  wire logic [CHANNELS-1:0]     recoveredClock,
	input  wire logic [CHANNELS-1:0]     referenceClock,
	input  wire logic [CHANNELS-1:0]     signalAbsentCondition,
	input  wire logic                    boardTestFloat,
	input  wire logic                    chipSel_n,
	input  wire logic                    write_n,
	input  wire logic                    read_n,
	input  wire logic                    regReset_n,
	input  wire logic                    hostTimingSelect,
	input  wire logic                    hostClock,
	input  wire logic [`LAHP_ADDR_W-1:0] hostAddr,
	input  wire logic [`LAHP_DATA_W-1:0] hostDataIn,
	output logic      [`LAHP_DATA_W-1:0] hostDataOut,
	output logic                         hostDataOe_n,
	output logic                         interruptOut_n,
	output logic                         interruptOe_n,
	output logic      [CHANNELS-1:0]     driverFaultFlag,
	output logic      [CHANNELS-1:0]     rxSignalAbsentFlag,
	output logic      [CHANNELS-1:0]     rxLockFailureFlag,
	output logic                         alarmOe_n
);

	localparam int AW = $clog2(CMD_REGS);
	localparam int BW = `LAHP_ADDR_W + `LAHP_DATA_W;

	lahp_pkg::lahp_host_pins_t              hostS;
	lahp_pkg::lahp_alarm_t [CHANNELS-1:0]   chAlarm;
	logic [BW-1:0]                          busS;
	logic [`LAHP_DATA_W-1:0]                cmdRegs [CMD_REGS];
	logic [`LAHP_KINDS-1:0][CHANNELS-1:0]   alarmNow;
	logic [`LAHP_KINDS-1:0][CHANNELS-1:0]   alarmPrev;
	logic [`LAHP_KINDS-1:0][CHANNELS-1:0]   eventSticky;
	logic [`LAHP_KINDS-1:0]                 intEnable;
	logic                                   hostClkPrev;
	logic                                   wrDone;

	// ------------------------------------------------------------------------
	// Pin sampling
	// ------------------------------------------------------------------------
	// Control pins idle at their inactive level so reset does not look like a strobe.
	lahp_sync2 #(
		.WIDTH ($bits(lahp_pkg::lahp_host_pins_t)),
		.INIT  (7'h79)
	) u_host_pins (
		.clk_sys (clk_sys),
		.rst     (rst),
		.din     ({chipSel_n, write_n, read_n, regReset_n,
		           hostTimingSelect, hostClock, boardTestFloat}),
		.dout    (hostS)
	);

	// Address and data are used as soon as the synchronised strobe is active, with no stability wait.
	lahp_sync2 #(
		.WIDTH (BW),
		.INIT  ('0)
	) u_host_bus (
		.clk_sys (clk_sys),
		.rst     (rst),
		.din     ({hostAddr, hostDataIn}),
		.dout    (busS)
	);

	// ------------------------------------------------------------------------
	// Channels
	// ------------------------------------------------------------------------
	// Each channel has its own clocks, counters and flags.
	for (genvar c = 0; c < CHANNELS; c++)
	begin : g_ch
		lahp_channel_alarm #(
			.IDLE_TXCLK  (IDLE_TXCLK),
			.LOCK_WINDOW (LOCK_WINDOW)
		) u_alarm (
			.clk_sys               (clk_sys),
			.rst                   (rst),
			.txLineClock           (txLineClock[c]),
			.monitorPosInput       (monitorPosInput[c]),
			.monitorNegInput       (monitorNegInput[c]),
			.recoveredClock        (recoveredClock[c]),
			.referenceClock        (referenceClock[c]),
			.signalAbsentCondition (signalAbsentCondition[c]),
			.alarm                 (chAlarm[c])
		);
		assign alarmNow[0][c] = chAlarm[c].driverFault;
		assign alarmNow[1][c] = chAlarm[c].signalAbsent;
		assign alarmNow[2][c] = chAlarm[c].lockFailure;
	end

	// ------------------------------------------------------------------------
	// Host access decode
	// ------------------------------------------------------------------------
	// In synchronous mode a write waits for a host clock edge; otherwise, and for
	// every read, each internal clock cycle is an access slot.
	wire [`LAHP_ADDR_W-1:0] addrS = busS[BW-1:`LAHP_DATA_W];
	wire [`LAHP_DATA_W-1:0] dataS = busS[`LAHP_DATA_W-1:0];
	wire [AW-1:0] cmdIndex   = addrS[AW-1:0];
	wire addrIsCmd   = addrS < `LAHP_ADDR_W'(CMD_REGS);
	wire hostClkRise = hostS.hostClock & ~hostClkPrev;
	wire accessSlot  = hostS.timingSel ? hostClkRise : 1'b1;
	wire csActive    = ~hostS.chipSelN;
	wire floatOk     = hostS.boardTestFloat;
	wire regsHeld    = ~hostS.regResetN;
	wire wrActive    = csActive & ~hostS.writeN & ~regsHeld;
	wire wrTake      = wrActive & ~wrDone & accessSlot;
	wire rdActive    = csActive & ~hostS.readN;
	wire evtHit      = addrS >= `LAHP_ADDR_EVENT && addrS < `LAHP_ADDR_INTEN;
	wire liveHit     = addrS >= `LAHP_ADDR_LIVE &&
	                   addrS < `LAHP_ADDR_LIVE + `LAHP_ADDR_W'(`LAHP_KINDS);
	wire [1:0] evtKind  = 2'(addrS - `LAHP_ADDR_EVENT);
	wire [1:0] liveKind = 2'(addrS - `LAHP_ADDR_LIVE);

	// Read selection; unmapped addresses read as zero.
	wire [`LAHP_DATA_W-1:0] readValue =
		addrIsCmd                  ? cmdRegs[cmdIndex] :
		evtHit                     ? `LAHP_DATA_W'(eventSticky[evtKind]) :
		addrS == `LAHP_ADDR_INTEN  ? `LAHP_DATA_W'(intEnable) :
		liveHit                    ? `LAHP_DATA_W'(alarmNow[liveKind]) :
		                             `LAHP_DATA_W'(0);

	// Interrupt request: any enabled kind with a pending channel event.
	logic [`LAHP_KINDS-1:0] kindPending;
	always_comb
	begin
		kindPending = '0;
		for (int k = 0; k < `LAHP_KINDS; k++)
			kindPending[k] = (|eventSticky[k]) & intEnable[k];
	end
	wire intPending = |kindPending;

	// ------------------------------------------------------------------------
	// Command registers
	// ------------------------------------------------------------------------
	// A write is taken once per strobe assertion, so a long strobe stores once.
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			hostClkPrev <= 1'b0;
			wrDone      <= 1'b0;
		end
		else
		begin
			hostClkPrev <= hostS.hostClock;
			wrDone      <= wrActive & (wrDone | wrTake);
		end
	end

	// Register reset is held on the array for as long as the pin stays low.
	always_ff @(posedge clk_sys)
	begin
		if (rst || regsHeld)
		begin
			for (int r = 0; r < CMD_REGS; r++)
				cmdRegs[r] <= `LAHP_CMD_RESET;
		end
		else if (wrTake && addrIsCmd)
			cmdRegs[cmdIndex] <= dataS;
	end

	// ------------------------------------------------------------------------
	// Alarm events and interrupt state
	// ------------------------------------------------------------------------
	// A rising alarm sets its event bit even when the same bit is being cleared.
	always_ff @(posedge clk_sys)
	begin
		if (rst || regsHeld)
		begin
			alarmPrev   <= '0;
			eventSticky <= '0;
			intEnable   <= `LAHP_INTEN_RESET;
		end
		else
		begin
			alarmPrev <= alarmNow;
			for (int k = 0; k < `LAHP_KINDS; k++)
			begin
				if (wrTake && evtHit && evtKind == 2'(k))
					eventSticky[k] <= (eventSticky[k] & ~dataS[CHANNELS-1:0]) |
					                  (alarmNow[k] & ~alarmPrev[k]);
				else
					eventSticky[k] <= eventSticky[k] | (alarmNow[k] & ~alarmPrev[k]);
			end
			if (wrTake && addrS == `LAHP_ADDR_INTEN)
				intEnable <= dataS[`LAHP_KINDS-1:0];
		end
	end

	// ------------------------------------------------------------------------
	// Pin drivers
	// ------------------------------------------------------------------------
	// All enables are released while the float input is low, but state is kept so
	// that the board returns to the same picture after in-circuit test.
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			hostDataOut        <= '0;
			hostDataOe_n       <= 1'b1;
			interruptOut_n     <= 1'b0;
			interruptOe_n      <= 1'b1;
			driverFaultFlag    <= '0;
			rxSignalAbsentFlag <= '0;
			rxLockFailureFlag  <= '0;
			alarmOe_n          <= 1'b1;
		end
		else
		begin
			hostDataOut        <= rdActive ? readValue : hostDataOut;
			hostDataOe_n       <= ~(rdActive & floatOk);
			interruptOut_n     <= 1'b0;
			interruptOe_n      <= ~(intPending & floatOk);
			driverFaultFlag    <= alarmNow[0];
			rxSignalAbsentFlag <= alarmNow[1];
			rxLockFailureFlag  <= alarmNow[2];
			alarmOe_n          <= ~floatOk;
		end
	end

	// ------------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	sequence s_async_strobe;
		!hostS.timingSel && wrActive && !wrDone;
	endsequence

	sequence s_read_held;
		(rdActive && floatOk) [*2];
	endsequence

	a_float_hiz: assert property (!floatOk |=> hostDataOe_n && alarmOe_n && interruptOe_n)
		else $error("outputs driven while float input low");
	a_cs_ignore: assert property (hostS.chipSelN |-> !wrTake ##1 hostDataOe_n)
		else $error("host bus used without chip select");
	a_write_store: assert property (wrTake && addrIsCmd |=> cmdRegs[$past(cmdIndex)] == $past(dataS))
		else $error("write strobe did not store data");
	a_write_once: assert property (wrTake |=> !wrTake)
		else $error("one strobe stored twice");
	a_read_drive: assert property (s_read_held |-> !hostDataOe_n && hostDataOut == $past(readValue))
		else $error("read data not driven");
	a_reg_reset: assert property (regsHeld |=> intEnable == 3'h0 && eventSticky == '0 && cmdRegs[0] == 8'h00)
		else $error("register reset did not restore defaults");
	a_sync_slot: assert property (hostS.timingSel && wrTake |-> hostClkRise)
		else $error("synchronous write off a host clock edge");
	a_async_slot: assert property (s_async_strobe |-> wrTake)
		else $error("asynchronous write not taken");
	a_int_assert: assert property (intPending && floatOk |=> !interruptOe_n && !interruptOut_n)
		else $error("interrupt not driven low");
	// The pin lags the pending state by one cycle, so a clear in the previous cycle
	// may still release it; only a quiet pair of cycles must keep it low.
	a_int_hold: assert property (!interruptOe_n && floatOk && !wrTake && !regsHeld &&
		!$past(wrTake) && !$past(regsHeld) |=> !interruptOe_n)
		else $error("interrupt released before service");

endmodule

// ==== hw/lahp_sync2.sv ====
// Two flip-flop synchroniser for a group of level signals.
// Assumes each bit is a level that changes slower than clk_sys.
module lahp_sync2 #(
	parameter int               WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT  = '0
) (
	input  wire logic             clk_sys,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);

	logic [WIDTH-1:0] stage1;

	// The first stage feeds only the second; the value starts at the pins' idle level.
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			stage1 <= INIT;
			dout   <= INIT;
		end
		else
		begin
			stage1 <= din;
			dout   <= stage1;
		end
	end

endmodule

// ==== verification/lahp_host_model.sv ====
// Behavioural host processor on the parallel port of the alarm block.
// Assumes the bench calls its tasks and that clk_sys runs at 100 MHz.
module lahp_host_model (
	input  wire logic       clk_sys,
	input  wire logic [7:0] hostDataOut,
	input  wire logic       hostDataOe_n,
	output logic            chipSel_n,
	output logic            write_n,
	output logic            read_n,
	output logic            regReset_n,
	output logic            hostTimingSelect,
	output logic            hostClock,
	output logic [7:0]      hostAddr,
	output logic [7:0]      hostDataIn
);
	timeunit 1ns;
	timeprecision 1ns;
	logic       drive = 1'b0;
	logic       clkRun = 1'b0;
	logic [7:0] wData = 8'h00;

	// A floating bus shows the inverse of our last value, so a stale read never matches the value last written.
	assign hostDataIn = !hostDataOe_n ? hostDataOut : (drive ? wData : ~wData);

	// Host bus clock of 25 MHz, far under the 66 MHz ceiling; it stands still when idle.
	initial
	begin
		hostClock = 1'b0;
		forever #20 hostClock = clkRun & ~hostClock;
	end

	// All strobes idle and the port in internal clock mode at time zero.
	initial
	begin
		{chipSel_n, write_n, read_n, regReset_n} = 4'hf;
		hostTimingSelect = 1'b0;
		hostAddr = 8'h00;
	end

	// One store per strobe; address and data stand for the whole strobe.
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic sel);
		@(negedge clk_sys);
		hostAddr = a;
		wData = d;
		drive = 1'b1;
		chipSel_n = ~sel;
		write_n = 1'b0;
		repeat (10) @(negedge clk_sys);
		{chipSel_n, write_n, drive} = 3'b110;
		repeat (5) @(negedge clk_sys);
	endtask

	// A read waits a bounded time for the device to drive; ok tells whether it did.
	task automatic rd(input logic [7:0] a, input logic sel, output logic [7:0] d,
		output logic ok);
		int i;
		ok = 1'b0;
		@(negedge clk_sys);
		hostAddr = a;
		chipSel_n = ~sel;
		read_n = 1'b0;
		for (i = 0; i < 12 && !ok; i++)
		begin
			@(negedge clk_sys);
			ok = (hostDataOe_n === 1'b0);
		end
		d = hostDataIn;
		{chipSel_n, read_n} = 2'b11;
		repeat (5) @(negedge clk_sys);
	endtask
endmodule

// ==== verification/tb.sv ====
// Self-checking bench of the line alarm and host port block.
// Assumes the host model file and the design's default idle count of transmit clocks.
`include "lahp_defs.svh"
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int CH = `LAHP_CHANNELS;
	typedef struct packed { logic [7:0] a; logic [7:0] d; logic [7:0] e; } lahp_row_t;
	localparam lahp_row_t ROWS [7] = '{'{8'h00, 8'ha5, 8'ha5}, '{8'h1f, 8'h5a, 8'h5a},
		'{8'h20, 8'h77, 8'h00}, '{8'h80, 8'h3c, 8'h00}, '{8'h43, 8'h05, 8'h05},
		'{8'h44, 8'hff, 8'h00}, '{8'h40, 8'hff, 8'h00}};
	localparam logic [7:0] CLEARED [3] = '{8'h00, 8'h03, 8'h43};
	logic          clk_sys = 1'b0;
	logic          rst = 1'b1;
	logic          linkClk = 1'b0;
	logic          slowClk = 1'b0;
	logic          monTog = 1'b0;
	logic          boardTestFloat = 1'b1;
	logic [CH-1:0] monActive = '1;
	logic [CH-1:0] monNeg = '0;
	logic [CH-1:0] badMask = '0;
	logic [CH-1:0] absent = '0;
	logic [CH-1:0] fault, absFlag, lockFlag;
	logic [7:0]    hAddr, hIn, hOut, rdData;
	logic          cs_n, wr_n, rd_n, rr_n, tsel, hClk, dOe_n, irqOut_n, irqOe_n, aOe_n, ok;
	int            failures = 0;
	int            checksDone = 0;
	int            n;

	// System clock, an 80 ns link clock of unrelated phase, and a slow 100 ns clock.
	initial forever #5 clk_sys = ~clk_sys;
	initial #3 forever #40 linkClk = ~linkClk;
	initial forever #50 slowClk = ~slowClk;
	// Monitor pulses every 16 cycles keep the live channels far from the idle limit.
	initial forever begin repeat (16) @(negedge clk_sys); monTog = ~monTog; end

	lahp_line_alarm_top #(.LOCK_WINDOW(200)) dut (.clk_sys(clk_sys), .rst(rst),
		.txLineClock({CH{linkClk}}), .monitorPosInput(monActive & {CH{monTog}}),
		.monitorNegInput(monNeg), .referenceClock({CH{linkClk}}),
		.recoveredClock((badMask & {CH{slowClk}}) | (~badMask & {CH{linkClk}})),
		.signalAbsentCondition(absent), .boardTestFloat(boardTestFloat),
		.chipSel_n(cs_n), .write_n(wr_n), .read_n(rd_n), .regReset_n(rr_n),
		.hostTimingSelect(tsel), .hostClock(hClk), .hostAddr(hAddr), .hostDataIn(hIn),
		.hostDataOut(hOut), .hostDataOe_n(dOe_n), .interruptOut_n(irqOut_n),
		.interruptOe_n(irqOe_n), .driverFaultFlag(fault), .rxSignalAbsentFlag(absFlag),
		.rxLockFailureFlag(lockFlag), .alarmOe_n(aOe_n));

	lahp_host_model host (.clk_sys(clk_sys), .hostDataOut(hOut), .hostDataOe_n(dOe_n),
		.chipSel_n(cs_n), .write_n(wr_n), .read_n(rd_n), .regReset_n(rr_n),
		.hostTimingSelect(tsel), .hostClock(hClk), .hostAddr(hAddr), .hostDataIn(hIn));

	// ------------------------------------------------------------------------
	// Checking and closing
	// ------------------------------------------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checksDone++;
		if (got !== exp)
		begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic end_of_test();
		$display("Checks %0d, failures %0d", checksDone, failures);
		if (failures == 0 && checksDone > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Bounded wait for an exact alarm pattern; n keeps the cycles spent.
	task automatic waitFor(input int kind, input logic [5:0] pat, input int lim);
		logic [5:0] v;
		for (n = 0; n < lim; n++)
		begin
			@(negedge clk_sys);
			v = kind == 0 ? fault : (kind == 1 ? absFlag : lockFlag);
			if (v === pat)
				return;
		end
		failures++;
		$display("Error at %0t: alarm wait ran out", $time);
		end_of_test();
	endtask

	// Reset, the register rows, then the awkward cases by hand.
	initial
	begin
		repeat (4) @(negedge clk_sys);
		chk(8'({dOe_n, irqOe_n, aOe_n}), 8'h07);
		chk(8'(fault | absFlag | lockFlag), 8'h00);
		rst = 1'b0;
		repeat (5) @(negedge clk_sys);
		chk(8'(aOe_n), 8'h00);
		foreach (ROWS[i])
		begin
			host.wr(ROWS[i].a, ROWS[i].d, 1'b1);
			host.rd(ROWS[i].a, 1'b1, rdData, ok);
			chk(rdData, ROWS[i].e);
		end
		host.wr(8'h01, 8'h99, 1'b0);
		host.rd(8'h01, 1'b0, rdData, ok);
		chk(8'(ok), 8'h00);
		host.rd(8'h01, 1'b1, rdData, ok);
		chk(rdData, 8'h00);
		host.regReset_n = 1'b0;
		host.wr(8'h03, 8'h11, 1'b1);
		host.regReset_n = 1'b1;
		foreach (CLEARED[i])
		begin
			host.rd(CLEARED[i], 1'b1, rdData, ok);
			chk(rdData, 8'h00);
		end
		// Synchronous mode stores nothing until the host clock runs.
		host.hostTimingSelect = 1'b1;
		host.wr(8'h04, 8'hc3, 1'b1);
		host.rd(8'h04, 1'b1, rdData, ok);
		chk(rdData, 8'h00);
		host.clkRun = 1'b1;
		host.wr(8'h04, 8'hc3, 1'b1);
		host.rd(8'h04, 1'b1, rdData, ok);
		chk(rdData, 8'hc3);
		{host.clkRun, host.hostTimingSelect} = 2'b00;
		// Idle monitor on channel 0 only; the interrupt outlives the returning pulses, the flag does not.
		host.wr(8'h43, 8'h01, 1'b1);
		monActive[0] = 1'b0;
		waitFor(0, 6'h01, 1600);
		chk(8'(n >= 760 && n <= 1290), 8'h01);
		// The event bit is set with the top flag; the interrupt pin follows one cycle later.
		@(negedge clk_sys);
		chk(8'(irqOe_n), 8'h00);
		chk(8'(irqOut_n), 8'h00);
		monNeg[0] = 1'b1;
		waitFor(0, 6'h00, 10);
		host.rd(8'h40, 1'b1, rdData, ok);
		chk(rdData, 8'h01);
		chk(8'(irqOe_n), 8'h00);
		host.wr(8'h40, 8'h01, 1'b1);
		chk(8'(irqOe_n), 8'h01);
		monActive[0] = 1'b1;
		absent = 6'h04;
		waitFor(1, 6'h04, 8);
		absent = 6'h00;
		waitFor(1, 6'h00, 8);
		badMask = 6'h20;
		waitFor(2, 6'h20, 4000);
		badMask = 6'h00;
		waitFor(2, 6'h00, 4000);
		boardTestFloat = 1'b0;
		repeat (5) @(negedge clk_sys);
		chk(8'(aOe_n), 8'h01);
		host.rd(8'h00, 1'b1, rdData, ok);
		chk(8'(ok), 8'h00);
		end_of_test();
	end
endmodule
